// file: tb/dpfc_cell_model.sv
// behavioural cell array answering program and erase pulses with verify results
`timescale 1ns/100ps
`default_nettype none
module dpfc_cell_model (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // knobs from the bench
  input  wire logic [3:0]  verify_lat,
  input  wire logic        fail_once,
  // cell side of the controller
  input  wire logic        cell_margin,
  input  wire logic [21:0] cell_raddr,
  output logic             verify_valid,
  output logic             verify_pass,
  output logic      [15:0] cell_rdata
);
  logic [3:0] wait_q;
  logic       failed_q;
  // array content is a fixed pattern of the address, so the bench can predict it
  assign cell_rdata = ~cell_raddr[15:0];
  // one verify answer per margin phase after a slow settle; the first may fail on request
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wait_q       <= 4'h0;
      failed_q     <= 1'b0;
      verify_valid <= 1'b0;
      verify_pass  <= 1'b0;
    end else begin
      verify_valid <= cell_margin && !verify_valid && wait_q == verify_lat;
      verify_pass  <= !(fail_once && !failed_q);
      wait_q       <= (cell_margin && !verify_valid && wait_q != verify_lat) ? wait_q + 4'h1 : 4'h0;
      if (verify_valid && fail_once) failed_q <= 1'b1;
      if (!fail_once) failed_q <= 1'b0;
    end
  end
endmodule : dpfc_cell_model
`default_nettype wire

// file: tb/testbench.sv
// self-checking bench for the flash control front end
`timescale 1ns/100ps
`default_nettype none
`include "dpfc_defines.svh"
`define CHK(a, e) check_eq(64'(a), 64'(e))
module testbench import dpfc_pkg::*;;
  logic        clk_sys = 1'b0;
  logic        rst_n, dev_rst_n, vpp_ok, fail_once, verify_valid, verify_pass;
  logic        dq_oe_n, cell_pulse, cell_margin, reg_wr, reg_rd;
  dpfc_bus_t   host_bus;
  dpfc_op_t    cell_op;
  dpfc_rmode_t cell_space;
  logic [15:0] dq_out, cell_rdata;
  logic [21:0] cell_raddr;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [3:0]  verify_lat;
  int          bad_count, num_checks, pulse_cnt;
  dpfc_flash_ctrl u_dpfc_flash_ctrl (.clk_sys(clk_sys), .rst_n(rst_n), .host_bus(host_bus), .dev_rst_n(dev_rst_n),
    .vpp_ok(vpp_ok), .top_param_strap(1'b0), .dq_out(dq_out), .dq_oe_n(dq_oe_n), .cell_op(cell_op),
    .cell_pulse(cell_pulse), .cell_margin(cell_margin), .verify_valid(verify_valid), .verify_pass(verify_pass),
    .cell_rdata(cell_rdata), .cell_raddr(cell_raddr), .cell_space(cell_space), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  dpfc_cell_model u_dpfc_cell_model (.clk_sys(clk_sys), .rst_n(rst_n), .verify_lat(verify_lat),
    .fail_once(fail_once), .cell_margin(cell_margin), .cell_raddr(cell_raddr), .verify_valid(verify_valid),
    .verify_pass(verify_pass), .cell_rdata(cell_rdata));
  // 20 MHz system clock
  initial begin
    forever #25 clk_sys = ~clk_sys;
  end
  // pulse tally shows how often the machine retried
  always @(posedge clk_sys) begin
    if (cell_pulse === 1'b1) pulse_cnt++;
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : give_verdict
  task automatic check_eq(input logic [63:0] a, input logic [63:0] e);
    num_checks++;
    if (a !== e) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, a, e);
    end
  endtask : check_eq
  // register port cycles, read data taken in the cycle after the strobe
  task automatic reg_cyc(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= wd;
    reg_wr    <= wr;
    reg_rd    <= !wr;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : reg_cyc
  // command write: one low cycle, taken when the strobes rise
  task automatic host_write(input logic [21:0] a, input logic [15:0] wd);
    @(posedge clk_sys);
    host_bus <= '{ce_n: 1'b0, oe_n: 1'b1, we_n: 1'b0, addr: a, wdata: wd};
    @(posedge clk_sys);
    host_bus <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: a, wdata: ~wd};
    @(posedge clk_sys);
  endtask : host_write
  task automatic cmd2(input logic [7:0] c, input logic [21:0] a, input logic [15:0] wd);
    host_write(a, {8'h00, c});
    host_write(a, wd);
  endtask : cmd2
  // read cycle, write strobe kept high throughout
  task automatic host_read(input logic [21:0] a, output logic [16:0] d);
    @(posedge clk_sys);
    host_bus <= '{ce_n: 1'b0, oe_n: 1'b0, we_n: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge clk_sys);
    #1 d = {dq_oe_n, dq_out};
    @(posedge clk_sys);
    host_bus.ce_n <= 1'b1;
    host_bus.oe_n <= 1'b1;
  endtask : host_read
  task automatic sr0_is(input logic [7:0] e);
    logic [31:0] d;
    reg_cyc(1'b0, `REG_SR, 32'h0000_0000, d);
    `CHK(d[7:0], e);
  endtask : sr0_is
  // bounded waits; running out ends the run
  task automatic wait_for(input logic pulse_not_ready);
    logic [31:0] d;
    for (int i = 0; i < 200; i++) begin
      if (pulse_not_ready) begin
        @(posedge clk_sys);
        #1 if (cell_pulse === 1'b1) return;
      end else begin
        reg_cyc(1'b0, `REG_SR, 32'h0000_0000, d);
        if ({d[31], d[23], d[15], d[7]} === 4'hF) return;
      end
    end
    bad_count++;
    $display("[FAIL] t=%0t wait ran out got=%h exp=%h", $time, d, 32'h8080_8080);
    give_verdict();
  endtask : wait_for
  task automatic t_defaults();
    logic [31:0] d;
    logic [16:0] r;
    reg_cyc(1'b1, `REG_SR, 32'hFFFF_FFFF, d);
    reg_cyc(1'b0, `REG_SR, 32'h0000_0000, d);
    `CHK(d, 32'h8080_8080);
    reg_cyc(1'b0, `REG_STAT, 32'h0000_0000, d);
    `CHK(d, 32'h0000_0030);
    reg_cyc(1'b0, `REG_RCR, 32'h0000_0000, d);
    `CHK(d, 32'h0000_8000);
    reg_cyc(1'b0, 8'h10, 32'h0000_0000, d);
    `CHK(d, 32'h0000_0000);
    host_read(22'h00_0005, r);
    `CHK(r, 17'h0_FFFA);
    host_write(22'h00_0000, {8'h00, `CMD_READ_ID});
    host_read(22'h00_0001, r);
    `CHK(r, {1'b0, `ID_DEVICE});
    host_read(22'h00_0002, r);
    `CHK(r, 17'h0_0001);
    host_write(22'h00_0000, {8'h00, `CMD_READ_QUERY});
    host_read(22'h00_0010, r);
    `CHK({cell_space, r}, {RM_QUERY, 17'h0_FFEF});
  endtask : t_defaults
  task automatic t_locked();
    logic [16:0] r;
    cmd2(`CMD_PROG_SETUP, 22'h00_8010, 16'h1234);
    sr0_is(8'h92);
    host_read(22'h00_8010, r);
    `CHK(r[16:0], {9'h000, 8'h92});
    host_write(22'h00_8000, {8'h00, `CMD_CLR_STATUS});
    sr0_is(8'h80);
    cmd2(`CMD_ERASE_SETUP, 22'h00_8000, 16'h00FF);
    sr0_is(8'hB0);
    host_write(22'h00_8000, {8'h00, `CMD_CLR_STATUS});
    host_write(22'h00_8000, {8'h00, `CMD_READ_ARRAY});
    host_read(22'h00_8010, r);
    `CHK(r, 17'h0_7FEF);
  endtask : t_locked
  task automatic t_program();
    logic [31:0] d;
    logic [16:0] r;
    cmd2(`CMD_LOCK_SETUP, 22'h00_8000, {8'h00, `CMD_CONFIRM});
    fail_once  <= 1'b1;
    verify_lat <= 4'hF;
    cmd2(`CMD_PROG_SETUP, 22'h00_8010, 16'h1234);
    wait_for(1'b1);
    `CHK({cell_op.kind, cell_op.addr, cell_op.data}, {OP_PROG, 22'h00_8010, 16'h1234});
    host_read(22'h10_0004, r);
    `CHK(r, 17'h0_FFFB);
    reg_cyc(1'b0, `REG_SR, 32'h0000_0000, d);
    `CHK({d[15:8], d[7]}, 9'h100);
    wait_for(1'b0);
    `CHK(pulse_cnt, 2);
    sr0_is(8'h80);
    fail_once <= 1'b0;
  endtask : t_program
  task automatic t_otp();
    logic [31:0] d;
    cmd2(`CMD_OTP_SETUP, 22'h00_0089, 16'h5555);
    sr0_is(8'h90);
    host_write(22'h00_0000, {8'h00, `CMD_CLR_STATUS});
    // small part: top address bit dropped, so the window edge 88H is reached from above
    reg_cyc(1'b1, `REG_CFG, 32'h0000_0001, d);
    cmd2(`CMD_OTP_SETUP, 22'h20_0088, 16'h5555);
    wait_for(1'b1);
    `CHK({cell_op.kind, cell_op.addr}, {OP_OTP, 22'h20_0088});
    wait_for(1'b0);
    reg_cyc(1'b0, `REG_SR, 32'h0000_0000, d);
    `CHK(d[15:0], 16'h8080);
  endtask : t_otp
  task automatic t_vpp();
    vpp_ok <= 1'b0;
    cmd2(`CMD_LOCK_SETUP, 22'h00_8000, {8'h00, `CMD_LOCK_SET});
    cmd2(`CMD_LOCK_SETUP, 22'h01_0000, {8'h00, `CMD_CONFIRM});
    cmd2(`CMD_PROG_SETUP, 22'h01_0004, 16'h00FF);
    sr0_is(8'h98);
    host_write(22'h00_0000, {8'h00, `CMD_CLR_STATUS});
    vpp_ok <= 1'b1;
    cmd2(`CMD_PROG_SETUP, 22'h00_8004, 16'h00FF);
    sr0_is(8'h92);
    host_write(22'h00_0000, {8'h00, `CMD_CLR_STATUS});
    cmd2(`CMD_PROG_SETUP, 22'h01_0004, 16'h00FF);
    wait_for(1'b0);
    sr0_is(8'h80);
  endtask : t_vpp
  task automatic t_devreset();
    logic [31:0] d;
    logic [16:0] r;
    dev_rst_n <= 1'b0;
    cmd2(`CMD_LOCK_SETUP, 22'h00_8000, {8'h00, `CMD_CONFIRM});
    host_read(22'h00_8000, r);
    `CHK(r[16], 1'b1);
    reg_cyc(1'b0, `REG_SR, 32'h0000_0000, d);
    `CHK(d, 32'h8080_8080);
    dev_rst_n <= 1'b1;
    cmd2(`CMD_PROG_SETUP, 22'h01_0004, 16'h00FF);
    sr0_is(8'h92);
  endtask : t_devreset
  // reset, then the scenarios in turn
  initial begin
    rst_n      = 1'b0;
    dev_rst_n  = 1'b1;
    vpp_ok     = 1'b1;
    fail_once  = 1'b0;
    verify_lat = 4'h3;
    host_bus   = '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: 22'h0, wdata: 16'h0};
    {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    t_defaults();
    t_locked();
    t_program();
    t_otp();
    t_vpp();
    t_devreset();
    give_verdict();
  end
endmodule : testbench
`default_nettype wire

// file: verilog/dpfc_defines.svh
// constants for the dual partition flash control front end
// Contract
// - bottom parts: lowest eight blocks are 4K-word, uniform blocks start at 008000H
// - blocks 39..70 sit contiguously from 100000H to 1FFFFFH, 8000H words each
// - one-time-programmable programming accepted only at word addresses 80H..88H
// - smaller density variant ignores the top address bit for OTP decoding
// - valid command starts erase, chip erase, program or OTP program autonomously
// - after reset the device reads asynchronously with 8-word page access
// - after reset planes 0-2 (top) or planes 1-3 (bottom) form one partition
// - after reset every block is locked and none is locked down
// - lock, read config and partition config commands work with low program supply
// - content changes start only by command and report through status
// - command address and data latch when chip enable or write strobe rises
// - state machine repeats pulses, verifies and margins without host help
// - last read-type command picks each partition's output source; the code also switches it to status on every other command except clear-status
// - array reads from other partitions proceed while one partition is busy
// - during suspend, other blocks may be read and programmed
// - each partition keeps its own 8-bit status register
// - ready bit reflects only its own partition, not the whole machine
// - status reports success or the cause of failure of the last operation
// - error bits set only by hardware, cleared by clear-status or reset
// - each block has its own lock and lock-down bit guarding its contents
// - while reset pin is low every write function is rejected
// - erase, chip erase, program, OTP program and lock need two command cycles
// - reset pin low tristates outputs and forces status to 80H
// - read-array command FFH returns the addressed partition to array read
`ifndef DPFC_DEFINES_SVH
`define DPFC_DEFINES_SVH
// command codes
`define CMD_READ_ARRAY   8'hFF
`define CMD_READ_STATUS  8'h70
`define CMD_READ_ID      8'h90
`define CMD_READ_QUERY   8'h98
`define CMD_CLR_STATUS   8'h50
`define CMD_ERASE_SETUP  8'h20
`define CMD_CHIP_SETUP   8'h30
`define CMD_PROG_SETUP   8'h40
`define CMD_OTP_SETUP    8'hC0
`define CMD_LOCK_SETUP   8'h60
`define CMD_SUSPEND      8'hB0
`define CMD_CONFIRM      8'hD0
`define CMD_LOCK_SET     8'h01
`define CMD_LOCK_DOWN    8'h2F
`define CMD_SET_RCR      8'h03
`define CMD_SET_PCR      8'h04
// status bit positions and values
`define SR_READY   7
`define SR_ESUSP   6
`define SR_EERR    5
`define SR_PERR    4
`define SR_VPPLOW  3
`define SR_PSUSP   2
`define SR_LOCKED  1
`define SR_RESET   8'h80
`define SR_KEEP    8'hC5
// address map
`define UNIFORM_BASE 22'h00_8000
`define PARAM_BLOCKS 8'h07
`define NUM_BLOCKS   135
`define OTP_LO       22'h00_0080
`define OTP_HI       22'h00_0088
// partition start masks, bit i set when a partition starts at plane i
`define PCR_BOTTOM 4'h3
`define PCR_TOP    4'h9
// read configuration reset: bit 15 asynchronous page mode, 8-word page
`define RCR_RESET  16'h8000
// identifier offsets and arbitrary codes
`define ID_OFS_MAKER 8'h00
`define ID_OFS_DEV   8'h01
`define ID_OFS_LOCK  8'h02
`define ID_OFS_RCR   8'h05
`define ID_OFS_PCR   8'h06
`define ID_MAKER     16'h00_A5
`define ID_DEVICE    16'h00_5A
// write state machine pulse limit
`define PULSE_MAX  4'hA
// register bus byte offsets
`define REG_CFG    8'h00
`define REG_SR     8'h04
`define REG_STAT   8'h08
`define REG_RCR    8'h0C
`endif

// file: verilog/dpfc_flash_ctrl.sv
// command interface, write state machine, status and protection of the flash front end
//
// The implementer's own choices: strobed register access and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "dpfc_defines.svh"
module dpfc_flash_ctrl import dpfc_pkg::*; (
  // clock and system reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // host pins
  input  wire dpfc_bus_t   host_bus,
  input  wire logic        dev_rst_n,
  input  wire logic        vpp_ok,
  input  wire logic        top_param_strap,
  output logic      [15:0] dq_out,
  output logic             dq_oe_n,
  // cell array
  output dpfc_op_t         cell_op,
  output logic             cell_pulse,
  output logic             cell_margin,
  input  wire logic        verify_valid,
  input  wire logic        verify_pass,
  input  wire logic [15:0] cell_rdata,
  output logic      [21:0] cell_raddr,
  output dpfc_rmode_t      cell_space,
  // register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata
);
  logic [1:0]        rst_sync_q;
  logic              srst_n;
  logic              strap_done_q;
  logic              top_q;
  logic              small_q;
  logic              wr_act;
  logic              wr_act_q;
  logic [21:0]       lat_addr_q;
  logic [15:0]       lat_data_q;
  logic              cmd_stb;
  logic [7:0]        cmd;
  logic [1:0]        cp;
  logic [7:0]        cblk;
  dpfc_pend_t        pend_q;
  dpfc_wsm_t         st_q;
  dpfc_op_t          op_q;
  dpfc_op_t          sv_q;
  logic              sv_valid_q;
  logic [3:0]        cnt_q;
  logic              pulse_q;
  logic [7:0]        sr_q [4];
  dpfc_rmode_t       rmode_q [4];
  logic [`NUM_BLOCKS-1:0] lock_q;
  logic [`NUM_BLOCKS-1:0] lockdn_q;
  logic [3:0]        pmask_q;
  logic [15:0]       rcr_q;
  logic              idle;
  logic              block_ok;
  logic              rd_en;
  logic [1:0]        rd_part;
  dpfc_rmode_t       rd_mode;
  logic [7:0]        rd_blk;
  logic [15:0]       id_word;
  logic [15:0]       rd_word;
  logic [31:0]       reg_word;

  // block number of a word address: eight 4K-word blocks, then 32K-word blocks
  function automatic logic [7:0] blk_of(input logic [21:0] a);
    blk_of = (a < `UNIFORM_BASE) ? {5'h00, a[14:12]} : ({1'b0, a[21:15]} + `PARAM_BLOCKS);
  endfunction : blk_of

  // OTP program window, top address bit dropped on the small part
  function automatic logic otp_ok(input logic [21:0] a, input logic sm);
    logic [21:0] m;
    m = sm ? {1'b0, a[20:0]} : a;
    otp_ok = (m >= `OTP_LO) && (m <= `OTP_HI);
  endfunction : otp_ok

  // partition of a plane: the nearest partition start at or below it
  function automatic logic [1:0] part_of(input logic [1:0] pl, input logic [3:0] m);
    part_of = 2'h0;
    for (int i = 0; i < 4; i++) begin
      if (i <= int'(pl) && m[i]) part_of = 2'(i);
    end
  endfunction : part_of

  // system reset released through two flops
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) rst_sync_q <= 2'b00;
    else rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign srst_n = rst_sync_q[1];

  // strap caught once after release
  always_ff @(posedge clk_sys or negedge srst_n) begin
    if (!srst_n) begin
      strap_done_q <= 1'b0;
      top_q        <= 1'b0;
    end else if (!strap_done_q) begin
      strap_done_q <= 1'b1;
      top_q        <= top_param_strap;
    end
  end

  // write capture: values of the last low-low cycle latch when either strobe rises
  assign wr_act  = !host_bus.ce_n && !host_bus.we_n && dev_rst_n;
  assign cmd_stb = wr_act_q && !wr_act && dev_rst_n;
  always_ff @(posedge clk_sys or negedge srst_n) begin
    if (!srst_n) begin
      wr_act_q   <= 1'b0;
      lat_addr_q <= 22'h00_0000;
      lat_data_q <= 16'h0000;
    end else begin
      wr_act_q <= wr_act;
      if (wr_act) begin
        lat_addr_q <= host_bus.addr;
        lat_data_q <= host_bus.wdata;
      end
    end
  end

  // command decode shared by the interface
  assign cmd      = lat_data_q[7:0];
  assign cp       = part_of(lat_addr_q[21:20], pmask_q);
  assign cblk     = blk_of(lat_addr_q);
  assign idle     = (st_q == S_IDLE);
  // suspended block may not be touched, erase not nested
  assign block_ok = !sv_valid_q || (cblk != sv_q.block);
  assign cell_op     = op_q;
  assign cell_pulse  = pulse_q;
  assign cell_margin = (st_q == S_VERIFY);

  // command interface, write state machine and status in one place so status has one writer
  always_ff @(posedge clk_sys or negedge srst_n) begin
    if (!srst_n) begin
      pend_q     <= P_NONE;
      st_q       <= S_IDLE;
      op_q       <= '0;
      sv_q       <= '0;
      sv_valid_q <= 1'b0;
      cnt_q      <= 4'h0;
      pulse_q    <= 1'b0;
      sr_q       <= '{default: `SR_RESET};
      rmode_q    <= '{default: RM_ARRAY};
      lock_q     <= '1;
      lockdn_q   <= '0;
      pmask_q    <= `PCR_BOTTOM;
      rcr_q      <= `RCR_RESET;
    end else if (!dev_rst_n) begin
      // reset pin aborts everything and restores the power-up defaults
      pend_q     <= P_NONE;
      st_q       <= S_IDLE;
      sv_valid_q <= 1'b0;
      cnt_q      <= 4'h0;
      pulse_q    <= 1'b0;
      sr_q       <= '{default: `SR_RESET};
      rmode_q    <= '{default: RM_ARRAY};
      rcr_q      <= `RCR_RESET;
      lock_q     <= '1;
      lockdn_q   <= '0;
      pmask_q    <= top_q ? `PCR_TOP : `PCR_BOTTOM;
    end else begin
      pulse_q <= 1'b0;
      // partition map follows the strap from the first cycle, not only after a pin reset
      if (!strap_done_q) pmask_q <= top_param_strap ? `PCR_TOP : `PCR_BOTTOM;
      if (cmd_stb && pend_q != P_NONE) begin
        // second cycle of a two-cycle sequence
        pend_q     <= P_NONE;
        rmode_q[cp] <= RM_STATUS;
        case (pend_q)
          P_LOCK: begin
            if (idle && cmd == `CMD_LOCK_SET) lock_q[cblk] <= 1'b1;
            else if (idle && cmd == `CMD_CONFIRM && !lockdn_q[cblk]) lock_q[cblk] <= 1'b0;
            else if (idle && cmd == `CMD_LOCK_DOWN) begin
              lock_q[cblk]   <= 1'b1;
              lockdn_q[cblk] <= 1'b1;
            end else if (cmd == `CMD_SET_RCR) rcr_q <= lat_addr_q[15:0];
            else if (cmd == `CMD_SET_PCR) pmask_q <= lat_addr_q[3:0] | 4'h1;
          end
          default: begin
            if ((pend_q == P_ERASE || pend_q == P_CHIP) && cmd != `CMD_CONFIRM) begin
              sr_q[cp][`SR_EERR] <= 1'b1;
              sr_q[cp][`SR_PERR] <= 1'b1;
            end else if (!idle || !block_ok || (sv_valid_q && pend_q != P_PROG)) begin
              sr_q[cp][`SR_PERR] <= 1'b1; // busy or suspended target refused
            end else if (!vpp_ok) begin
              sr_q[cp][`SR_VPPLOW] <= 1'b1;
              sr_q[cp][(pend_q == P_ERASE || pend_q == P_CHIP) ? `SR_EERR : `SR_PERR] <= 1'b1;
            end else if (pend_q == P_OTP && !otp_ok(lat_addr_q, small_q)) begin
              sr_q[cp][`SR_PERR] <= 1'b1;
            end else if ((pend_q == P_CHIP) ? (|lock_q) : (pend_q != P_OTP && lock_q[cblk])) begin
              sr_q[cp][`SR_LOCKED] <= 1'b1;
              sr_q[cp][(pend_q == P_PROG) ? `SR_PERR : `SR_EERR] <= 1'b1;
            end else begin
              op_q.kind  <= (pend_q == P_ERASE) ? OP_ERASE : (pend_q == P_CHIP) ? OP_CHIP :
                            (pend_q == P_OTP) ? OP_OTP : OP_PROG;
              op_q.addr  <= lat_addr_q;
              op_q.data  <= lat_data_q;
              op_q.block <= cblk;
              op_q.part  <= cp;
              cnt_q      <= 4'h0;
              st_q       <= S_PULSE;
              sr_q[cp][`SR_READY] <= 1'b0;
            end
          end
        endcase
      end else if (cmd_stb) begin
        // first cycle: read modes, setups and single-cycle commands
        case (cmd)
          `CMD_READ_ARRAY:  rmode_q[cp] <= RM_ARRAY;
          `CMD_READ_STATUS: rmode_q[cp] <= RM_STATUS;
          `CMD_READ_ID:     rmode_q[cp] <= RM_ID;
          `CMD_READ_QUERY:  rmode_q[cp] <= RM_QUERY;
          `CMD_CLR_STATUS:  sr_q[cp] <= sr_q[cp] & `SR_KEEP;
          `CMD_ERASE_SETUP: pend_q <= P_ERASE;
          `CMD_CHIP_SETUP:  pend_q <= P_CHIP;
          `CMD_PROG_SETUP:  pend_q <= P_PROG;
          `CMD_OTP_SETUP:   pend_q <= P_OTP;
          `CMD_LOCK_SETUP:  pend_q <= P_LOCK;
          `CMD_SUSPEND:     if (!idle && !sv_valid_q) pend_q <= P_NONE;
          `CMD_CONFIRM: begin
            // resume the suspended operation
            if (idle && sv_valid_q) begin
              op_q       <= sv_q;
              sv_valid_q <= 1'b0;
              st_q       <= S_PULSE;
              sr_q[sv_q.part][`SR_READY] <= 1'b0;
              sr_q[sv_q.part][`SR_ESUSP] <= 1'b0;
              sr_q[sv_q.part][`SR_PSUSP] <= 1'b0;
            end
          end
          default: pend_q <= P_NONE;
        endcase
        if (cmd != `CMD_READ_ARRAY && cmd != `CMD_READ_ID && cmd != `CMD_READ_QUERY && cmd != `CMD_CLR_STATUS)
          rmode_q[cp] <= RM_STATUS;
      end
      // write state machine: pulse, margin verify, retry up to the limit
      case (st_q)
        S_IDLE: ;
        S_PULSE: begin
          pulse_q <= 1'b1;
          st_q    <= S_VERIFY;
        end
        S_VERIFY: begin
          if (verify_valid && verify_pass) st_q <= S_DONE;
          else if (verify_valid && cmd_stb && pend_q == P_NONE && cmd == `CMD_SUSPEND && !sv_valid_q) begin
            // suspend only at a verify boundary so the cells never see a cut pulse
            sv_q       <= op_q;
            sv_valid_q <= 1'b1;
            st_q       <= S_IDLE;
            sr_q[op_q.part][`SR_READY] <= 1'b1;
            sr_q[op_q.part][(op_q.kind == OP_ERASE) ? `SR_ESUSP : `SR_PSUSP] <= 1'b1;
          end else if (verify_valid && cnt_q == `PULSE_MAX - 4'h1) begin
            sr_q[op_q.part][(op_q.kind == OP_ERASE || op_q.kind == OP_CHIP) ? `SR_EERR : `SR_PERR] <= 1'b1;
            st_q <= S_DONE;
          end else if (verify_valid) begin
            cnt_q <= cnt_q + 4'h1;
            st_q  <= S_PULSE;
          end
        end
        S_DONE: begin
          sr_q[op_q.part][`SR_READY] <= 1'b1;
          st_q <= S_IDLE;
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end

  // read selection per partition; array reads go on in any other partition
  assign rd_en      = !host_bus.ce_n && !host_bus.oe_n && host_bus.we_n && dev_rst_n;
  assign rd_part    = part_of(host_bus.addr[21:20], pmask_q);
  assign rd_mode    = rmode_q[rd_part];
  assign rd_blk     = blk_of(host_bus.addr);
  assign cell_raddr = host_bus.addr;
  assign cell_space = rd_mode;
  assign id_word    = (host_bus.addr >= `OTP_LO) ? cell_rdata :
                      (host_bus.addr[7:0] == `ID_OFS_MAKER) ? `ID_MAKER :
                      (host_bus.addr[7:0] == `ID_OFS_DEV) ? `ID_DEVICE :
                      (host_bus.addr[7:0] == `ID_OFS_LOCK) ? {14'h0000, lockdn_q[rd_blk], lock_q[rd_blk]} :
                      (host_bus.addr[7:0] == `ID_OFS_RCR) ? rcr_q :
                      (host_bus.addr[7:0] == `ID_OFS_PCR) ? {12'h000, pmask_q} : 16'h0000;
  assign rd_word    = (rd_mode == RM_STATUS) ? {8'h00, sr_q[rd_part]} :
                      (rd_mode == RM_ID) ? id_word : cell_rdata;
  always_ff @(posedge clk_sys or negedge srst_n) begin
    if (!srst_n) begin
      dq_out  <= 16'h0000;
      dq_oe_n <= 1'b1;
    end else begin
      dq_out  <= rd_word;
      dq_oe_n <= !rd_en;
    end
  end

  // register port: config, status bytes, machine state, read config
  assign reg_word = (reg_addr == `REG_CFG) ? {31'h0000_0000, small_q} :
                    (reg_addr == `REG_SR) ? {sr_q[3], sr_q[2], sr_q[1], sr_q[0]} :
                    (reg_addr == `REG_STAT) ? {23'h00_0000, top_q, pmask_q, 1'b0, sv_valid_q, st_q} :
                    (reg_addr == `REG_RCR) ? {16'h0000, rcr_q} : 32'h0000_0000;
  always_ff @(posedge clk_sys or negedge srst_n) begin
    if (!srst_n) begin
      small_q   <= 1'b0;
      reg_rdata <= 32'h0000_0000;
    end else begin
      if (reg_wr && reg_addr == `REG_CFG) small_q <= reg_wdata[0];
      reg_rdata <= reg_rd ? reg_word : 32'h0000_0000;
    end
  end

  // checks
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!srst_n);
  chk_reset_status: assert property (!dev_rst_n |=> sr_q[0] == `SR_RESET && sr_q[3] == `SR_RESET)
    else $error("status not 80H under reset");
  chk_reset_tristate: assert property (!dev_rst_n |=> dq_oe_n)
    else $error("outputs driven under reset");
  chk_reset_nowrite: assert property (!dev_rst_n |=> st_q == S_IDLE && !cell_pulse)
    else $error("write activity under reset");
  chk_otp_window: assert property (st_q == S_PULSE && op_q.kind == OP_OTP |-> otp_ok(op_q.addr, small_q))
    else $error("otp program outside window");
  chk_locked_block: assert property (st_q == S_PULSE && cnt_q == 4'h0 && op_q.kind == OP_PROG |-> !lock_q[op_q.block])
    else $error("program started on locked block");
  chk_pulse_verify: assert property (cell_pulse |-> !$past(cell_pulse) && cell_margin)
    else $error("pulse not followed by margin verify");
  chk_retry_bound: assert property (cnt_q < `PULSE_MAX)
    else $error("pulse count beyond limit");
  chk_busy_ready: assert property (st_q == S_PULSE |=> !sr_q[op_q.part][`SR_READY])
    else $error("ready set while busy");
  chk_reset_defaults: assert property ($rose(dev_rst_n) |-> &lock_q && !(|lockdn_q) && rcr_q == `RCR_RESET)
    else $error("power-up defaults wrong");
  cov_op_done: cover property (st_q == S_VERIFY ##1 st_q == S_DONE);
  cov_suspend: cover property (sv_valid_q && idle);
  cov_retry: cover property (verify_valid && !verify_pass ##[1:4] cell_pulse);
  cov_dual_read: cover property (!idle && rd_en && rd_part != op_q.part);
endmodule : dpfc_flash_ctrl
`default_nettype wire

// file: verilog/dpfc_pkg.sv
// types for the dual partition flash control front end
`default_nettype none
package dpfc_pkg;
  typedef enum logic [1:0] {RM_ARRAY, RM_STATUS, RM_ID, RM_QUERY} dpfc_rmode_t;
  typedef enum logic [2:0] {OP_ERASE, OP_CHIP, OP_PROG, OP_OTP} dpfc_kind_t;
  typedef enum logic [1:0] {S_IDLE = 2'b00, S_PULSE = 2'b01, S_VERIFY = 2'b11, S_DONE = 2'b10} dpfc_wsm_t;
  typedef enum logic [2:0] {P_NONE, P_ERASE, P_CHIP, P_PROG, P_OTP, P_LOCK} dpfc_pend_t;
  // host side strobes and address, sampled on clk_sys
  typedef struct packed {
    logic        ce_n;
    logic        oe_n;
    logic        we_n;
    logic [21:0] addr;
    logic [15:0] wdata;
  } dpfc_bus_t;
  // operation handed to the cell array
  typedef struct packed {
    dpfc_kind_t  kind;
    logic [21:0] addr;
    logic [15:0] data;
    logic [7:0]  block;
    logic [1:0]  part;
  } dpfc_op_t;
endpackage : dpfc_pkg
`default_nettype wire
